/* File: core/bit_sync.sv */
// two-flop level synchroniser for a group of independent bits
`default_nettype none
module bit_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // bit_sync
`default_nettype wire

/* File: core/lnb_pkg.sv */
// shared constants for the regulator two-wire register port
`default_nettype none
package lnb_pkg;
  // register select codes carried in the top bits of a written byte
  localparam logic [2:0] SEL_STATUS = 3'h0;
  localparam logic [2:0] SEL_TONE = 3'h1;
  localparam logic [2:0] SEL_CMD = 3'h2;
  localparam logic [2:0] SEL_CTRL = 3'h3;
  localparam int SEL_MSB = 7;
  localparam int SEL_LSB = 5;
  // slave address: upper five bits fixed, two low bits from pins
  localparam logic [4:0] ADDR_PREFIX = 5'h02;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [31:0] SNAP_RESET = 32'h0000_0000;
  // writable bits of each register, select code included
  localparam logic [7:0] TONE_WMASK = 8'hF8;
  localparam logic [7:0] CMD_WMASK = 8'hFB;
  localparam logic [7:0] CTRL_WMASK = 8'hF3;
  // tone register fields
  localparam int TONE_ON_POS = 4;
  localparam int MOD_SRC_POS = 3;
  localparam int THRESH_POS = 2;
  // command register fields
  localparam int LIMIT_MODE_POS = 4;
  localparam int PIN_EN_POS = 3;
  localparam int LIMIT_HIGH_POS = 1;
  localparam int LIMIT_LOW_POS = 0;
  // control register fields
  localparam int OUT_EN_POS = 4;
  localparam int HIGH_RANGE_POS = 1;
  localparam int LOW_RANGE_POS = 0;
  // read order of registers in the snapshot
  localparam logic [1:0] IDX_STATUS = 2'h0;
  localparam logic [1:0] IDX_TONE = 2'h1;
  localparam logic [1:0] IDX_CMD = 2'h2;
  localparam logic [1:0] IDX_CTRL = 2'h3;
endpackage
`default_nettype wire

/* File: core/lnb_regulator_i2c_register_port.sv */
// two-wire slave port and system registers of the supply regulator
`default_nettype none
module lnb_regulator_i2c_register_port (
  input wire logic clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic power_ok,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic address_pin_high,
  input wire logic address_pin_low,
  input wire logic external_modulation_pin,
  input wire logic tx_threshold_pin,
  input wire logic polarity_select_pin,
  input wire logic overtemp_flag,
  input wire logic open_cable_flag,
  input wire logic voltage_range_flag,
  input wire logic overload_flag,
  input wire logic back_current_flag,
  output logic tone_internal_on,
  output logic tone_external_pass,
  output logic [1:0] limit_select,
  output logic limit_static,
  output logic [1:0] voltage_select,
  output logic power_stage_en
);

  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_addr_ack,
    st_wr,
    st_wr_ack,
    st_rd,
    st_rd_ack
  } link_state_t;

  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] data,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (data & mask);
  endfunction

  function automatic logic [7:0] pick(input logic [31:0] snap_word,
                                      input logic [1:0] idx);
    case (idx)
      lnb_pkg::IDX_STATUS: pick = snap_word[7:0];
      lnb_pkg::IDX_TONE: pick = snap_word[15:8];
      lnb_pkg::IDX_CMD: pick = snap_word[23:16];
      default: pick = snap_word[31:24];
    endcase
  endfunction

  // crossing signals: toggles with data held stable by the sender
  logic wr_tog;
  logic rd_tog;
  logic [7:0] wr_data;
  logic [31:0] snap;

  // ---------------- link domain ----------------
  logic [4:0] l_sync;
  logic l_pok;
  logic scl_s;
  logic sda_s;
  logic addr_hi;
  logic addr_lo;
  logic scl_prev;
  logic sda_prev;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  link_state_t state;
  logic [2:0] cnt;
  logic full;
  logic [7:0] shift;
  logic [7:0] tx;
  logic is_read;
  logic more;
  logic [1:0] rd_idx;
  logic [7:0] rd_cur;
  logic [7:0] rd_nxt;

  bit_sync #(.W(5)) u_link_sync (
    .clk(link_clk),
    .nrst(nrst),
    .d({power_ok, scl_in, sda_in, address_pin_high, address_pin_low}),
    .q(l_sync)
  );

  assign l_pok = l_sync[4];
  assign scl_s = l_sync[3];
  assign sda_s = l_sync[2];
  assign addr_hi = l_sync[1];
  assign addr_lo = l_sync[0];
  assign rd_cur = pick(snap, rd_idx);
  assign rd_nxt = pick(snap, rd_idx + 2'h1);

  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_prev;
  assign scl_fall = ~scl_s & scl_prev;
  assign start_seen = scl_s & scl_prev & sda_prev & ~sda_s;
  assign stop_seen = scl_s & scl_prev & ~sda_prev & sda_s;

  // the device never drives a one; the line level is the wired-AND
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      state <= st_idle;
      cnt <= 3'h0;
      full <= 1'b0;
      shift <= 8'h00;
      tx <= 8'h00;
      sda_oe <= 1'b0;
      is_read <= 1'b0;
      more <= 1'b0;
      rd_idx <= 2'h0;
      wr_tog <= 1'b0;
      rd_tog <= 1'b0;
      wr_data <= 8'h00;
    end else if (!l_pok) begin
      state <= st_idle;
      sda_oe <= 1'b0;
      full <= 1'b0;
    end else if (stop_seen) begin
      state <= st_idle;
      sda_oe <= 1'b0;
      full <= 1'b0;
    end else if (start_seen) begin
      state <= st_addr;
      sda_oe <= 1'b0;
      cnt <= 3'h0;
      full <= 1'b0;
    end else begin
      case (state)
        st_addr, st_wr: begin
          if (scl_rise) begin
            // sampled on the rising edge, data is stable while high
            shift <= {shift[6:0], sda_s};
            cnt <= cnt + 3'h1;
            if (cnt == lnb_pkg::LAST_BIT) begin
              full <= 1'b1;
            end
          end else if (scl_fall && full) begin
            full <= 1'b0;
            if (state == st_wr) begin
              wr_data <= shift;
              wr_tog <= ~wr_tog;
              sda_oe <= 1'b1;
              state <= st_wr_ack;
            end else if (shift[7:3] == lnb_pkg::ADDR_PREFIX &&
                         shift[2:1] == {addr_hi, addr_lo}) begin
              sda_oe <= 1'b1;
              is_read <= shift[0];
              rd_idx <= lnb_pkg::IDX_STATUS;
              state <= st_addr_ack;
              if (shift[0]) begin
                rd_tog <= ~rd_tog;
              end
            end else begin
              state <= st_idle;
            end
          end
        end
        st_addr_ack: begin
          if (scl_fall) begin
            cnt <= 3'h0;
            if (is_read) begin
              tx <= rd_cur;
              sda_oe <= ~rd_cur[7];
              state <= st_rd;
            end else begin
              sda_oe <= 1'b0;
              state <= st_wr;
            end
          end
        end
        st_wr_ack: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            cnt <= 3'h0;
            state <= st_wr;
          end
        end
        st_rd: begin
          if (scl_fall) begin
            // release only after the fall that ends bit zero
            if (cnt == lnb_pkg::LAST_BIT) begin
              sda_oe <= 1'b0;
              state <= st_rd_ack;
            end else begin
              sda_oe <= ~tx[6];
              tx <= {tx[6:0], 1'b0};
              cnt <= cnt + 3'h1;
            end
          end
        end
        st_rd_ack: begin
          if (scl_rise) begin
            more <= ~sda_s;
          end else if (scl_fall) begin
            if (more) begin
              rd_idx <= rd_idx + 2'h1;
              tx <= rd_nxt;
              sda_oe <= ~rd_nxt[7];
              cnt <= 3'h0;
              state <= st_rd;
            end else begin
              state <= st_idle;
            end
          end
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // ---------------- system clock domain ----------------
  logic [10:0] c_sync;
  logic c_pok;
  logic req_s;
  logic wr_s;
  logic c_external_modulation_pin;
  logic c_txt;
  logic c_pol;
  logic [4:0] c_flags;
  logic req_prev;
  logic wr_prev;
  logic wr_event;
  logic req_event;
  logic [7:0] fault_status_reg;
  logic [7:0] tone_control_reg;
  logic [7:0] current_limit_command_reg;
  logic [7:0] output_voltage_control_reg;
  logic [7:0] next_tone;
  logic [7:0] next_cmd;
  logic [7:0] next_ctrl;
  logic [2:0] sel;

  bit_sync #(.W(11)) u_core_sync (
    .clk(clk),
    .nrst(nrst),
    .d({power_ok, rd_tog, wr_tog, external_modulation_pin,
        tx_threshold_pin, polarity_select_pin, overtemp_flag,
        open_cable_flag, voltage_range_flag, overload_flag,
        back_current_flag}),
    .q(c_sync)
  );

  assign c_pok = c_sync[10];
  assign req_s = c_sync[9];
  assign wr_s = c_sync[8];
  assign c_external_modulation_pin = c_sync[7];
  assign c_txt = c_sync[6];
  assign c_pol = c_sync[5];
  assign c_flags = c_sync[4:0];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req_prev <= 1'b0;
      wr_prev <= 1'b0;
    end else begin
      req_prev <= req_s;
      wr_prev <= wr_s;
    end
  end

  assign wr_event = wr_s ^ wr_prev;
  assign req_event = req_s ^ req_prev;
  assign sel = wr_data[lnb_pkg::SEL_MSB:lnb_pkg::SEL_LSB];

  always_comb begin
    next_tone = tone_control_reg;
    next_cmd = current_limit_command_reg;
    next_ctrl = output_voltage_control_reg;
    // status code and unknown codes change nothing
    if (wr_event) begin
      if (sel == lnb_pkg::SEL_TONE) begin
        next_tone = merge(tone_control_reg, wr_data,
                          lnb_pkg::TONE_WMASK);
      end else if (sel == lnb_pkg::SEL_CMD) begin
        next_cmd = merge(current_limit_command_reg, wr_data,
                         lnb_pkg::CMD_WMASK);
      end else if (sel == lnb_pkg::SEL_CTRL) begin
        next_ctrl = merge(output_voltage_control_reg, wr_data,
                          lnb_pkg::CTRL_WMASK);
      end
    end
    // threshold bit is read-only and follows its pin
    next_tone[lnb_pkg::THRESH_POS] = c_txt;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fault_status_reg <= lnb_pkg::REG_RESET;
      tone_control_reg <= lnb_pkg::REG_RESET;
      current_limit_command_reg <= lnb_pkg::REG_RESET;
      output_voltage_control_reg <= lnb_pkg::REG_RESET;
    end else if (!c_pok) begin
      fault_status_reg <= lnb_pkg::REG_RESET;
      tone_control_reg <= lnb_pkg::REG_RESET;
      current_limit_command_reg <= lnb_pkg::REG_RESET;
      output_voltage_control_reg <= lnb_pkg::REG_RESET;
    end else begin
      // live fault levels; writes never reach them
      fault_status_reg <= {3'h0, c_flags};
      tone_control_reg <= next_tone;
      current_limit_command_reg <= next_cmd;
      output_voltage_control_reg <= next_ctrl;
    end
  end

  // snapshot held stable for the link while a read is shifting
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      snap <= lnb_pkg::SNAP_RESET;
    end else if (req_event) begin
      snap <= {output_voltage_control_reg, current_limit_command_reg,
               tone_control_reg, fault_status_reg};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tone_internal_on <= 1'b0;
      tone_external_pass <= 1'b0;
      limit_select <= 2'h0;
      limit_static <= 1'b0;
      voltage_select <= 2'h0;
      power_stage_en <= 1'b0;
    end else if (!c_pok) begin
      tone_internal_on <= 1'b0;
      tone_external_pass <= 1'b0;
      limit_select <= 2'h0;
      limit_static <= 1'b0;
      voltage_select <= 2'h0;
      power_stage_en <= 1'b0;
    end else begin
      if (tone_control_reg[lnb_pkg::TONE_ON_POS]) begin
        tone_internal_on <= 1'b1;
      end else begin
        tone_internal_on <= ~tone_control_reg[lnb_pkg::MOD_SRC_POS] &
                            c_external_modulation_pin;
      end
      tone_external_pass <= ~tone_control_reg[lnb_pkg::TONE_ON_POS] &
                            tone_control_reg[lnb_pkg::MOD_SRC_POS];
      limit_select <= {current_limit_command_reg[lnb_pkg::LIMIT_HIGH_POS],
                       current_limit_command_reg[lnb_pkg::LIMIT_LOW_POS]};
      limit_static <=
        current_limit_command_reg[lnb_pkg::LIMIT_MODE_POS];
      if (current_limit_command_reg[lnb_pkg::PIN_EN_POS]) begin
        voltage_select <= {
          output_voltage_control_reg[lnb_pkg::HIGH_RANGE_POS],
          output_voltage_control_reg[lnb_pkg::LOW_RANGE_POS]};
      end else if (c_pol) begin
        voltage_select <= {1'b1,
          output_voltage_control_reg[lnb_pkg::HIGH_RANGE_POS]};
      end else begin
        voltage_select <= {1'b0,
          output_voltage_control_reg[lnb_pkg::LOW_RANGE_POS]};
      end
      power_stage_en <=
        output_voltage_control_reg[lnb_pkg::OUT_EN_POS];
    end
  end

endmodule // lnb_regulator_i2c_register_port
`default_nettype wire

/* File: test/lnb_host_model.sv */
// two-wire bus master model: drives clock, releases or pulls data
`default_nettype none
module lnb_host_model (
  output logic scl,
  output logic sda_rel,
  input wire logic sda_wire
);
  timeunit 1ns;
  timeprecision 100ps;
  // half clock period, well above the port's oversampling needs
  localparam int H = 1000;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // only called from idle, so every start but the first follows a stop
  task automatic start();
    sda_rel = 1'b0;
    #H;
    scl = 1'b0;
  endtask
  task automatic stop();
    #(H/2);
    sda_rel = 1'b0;
    #(H/2);
    scl = 1'b1;
    #H;
    sda_rel = 1'b1;
    #H;
  endtask
  // data moves only in the middle of the low phase
  task automatic bit_io(input logic b, output logic r);
    #(H/2);
    sda_rel = b;
    #(H/2);
    scl = 1'b1;
    #H;
    r = sda_wire;
    scl = 1'b0;
  endtask
  // acknowledge slot: released when sending, never checked here
  task automatic byte_io(input logic [7:0] d, input logic a_in,
      output logic [7:0] r, output logic a_out);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(a_in, a_out);
  endtask
endmodule // lnb_host_model
`default_nettype wire

/* File: test/lnb_port_asserts.sv */
// concurrent checks on the ports of the regulator register port
`default_nettype none
module lnb_port_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic power_ok,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic tone_internal_on,
  input wire logic tone_external_pass,
  input wire logic [1:0] limit_select,
  input wire logic limit_static,
  input wire logic [1:0] voltage_select,
  input wire logic power_stage_en
);
  a_ack_lockout: assert property (@(posedge link_clk) disable iff (!nrst)
    !power_ok [*5] |-> !sda_oe)
    else $error("data line pulled while supply is low");
  a_regs_lockout: assert property (@(posedge clk) disable iff (!nrst)
    !power_ok [*6] |-> !power_stage_en && limit_select == 2'h0
      && voltage_select == 2'h0 && !tone_internal_on && !limit_static)
    else $error("outputs not cleared while supply is low");
  a_reset_zero: assert property (@(posedge clk) disable iff (!nrst)
    !$past(nrst) |-> !power_stage_en && limit_select == 2'h0
      && voltage_select == 2'h0 && !tone_external_pass)
    else $error("outputs not zero after reset");
  a_drive_low: assert property (@(posedge link_clk) disable iff (!nrst)
    sda_oe |-> !sda_out)
    else $error("data line driven high");
  a_oe_scl_low: assert property (@(posedge link_clk) disable iff (!nrst)
    $changed(sda_oe) |-> !scl_in)
    else $error("data drive changed while clock high");
  a_ack_after_fall: assert property (@(posedge link_clk) disable iff (!nrst)
    $rose(sda_oe) |-> !$past(scl_in) && !$past(scl_in, 2))
    else $error("data drive started without a clock fall");
  a_ack_stands: assert property (@(posedge link_clk) disable iff (!nrst)
    $rose(sda_oe) |=> sda_oe [*8])
    else $error("data drive released too early");
  a_tone_exclusive: assert property (@(posedge clk) disable iff (!nrst)
    !(tone_internal_on && tone_external_pass))
    else $error("internal and external tone both on");
  c_ack: cover property (@(posedge link_clk) $rose(sda_oe));
  c_enable: cover property (@(posedge clk) $rose(power_stage_en));
  c_pass: cover property (@(posedge clk) $rose(tone_external_pass));
endmodule // lnb_port_asserts
bind lnb_regulator_i2c_register_port lnb_port_asserts lnb_port_asserts_i (
  .clk, .nrst, .link_clk, .power_ok, .scl_in, .sda_in, .sda_out, .sda_oe,
  .tone_internal_on, .tone_external_pass, .limit_select, .limit_static,
  .voltage_select, .power_stage_en);
`default_nettype wire

/* File: test/tb_lnb_regulator_i2c_register_port.sv */
// self-checking bench for the regulator two-wire register port
`default_nettype none
module tb_lnb_regulator_i2c_register_port;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] DEV = {lnb_pkg::ADDR_PREFIX, 2'b10};
  logic clk, link_clk, nrst = 1'b0, power_ok = 1'b1;
  logic ext = 1'b0, txp = 1'b0, pol = 1'b0;
  logic [4:0] flags = 5'h0A;
  logic scl, sda_rel, sda_wire, sda_out, sda_oe;
  logic tone_internal_on, tone_external_pass, limit_static, power_stage_en;
  logic [1:0] limit_select, voltage_select;
  logic [7:0] outs;
  logic [4:0] tab [4] = '{5'b10010, 5'b00000, 5'b00101, 5'b01010};
  int fail_count = 0;
  int checks_done = 0;
  assign sda_wire = sda_rel & ~sda_oe;
  assign outs = {tone_internal_on, tone_external_pass, limit_select,
    limit_static, voltage_select, power_stage_en};
  lnb_regulator_i2c_register_port lnb_regulator_i2c_register_port_i (
    .clk(clk),
    .nrst(nrst),
    .link_clk(link_clk),
    .power_ok(power_ok),
    .scl_in(scl),
    .sda_in(sda_wire),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .address_pin_high(1'b1),
    .address_pin_low(1'b0),
    .external_modulation_pin(ext),
    .tx_threshold_pin(txp),
    .polarity_select_pin(pol),
    .overtemp_flag(flags[4]),
    .open_cable_flag(flags[3]),
    .voltage_range_flag(flags[2]),
    .overload_flag(flags[1]),
    .back_current_flag(flags[0]),
    .tone_internal_on(tone_internal_on),
    .tone_external_pass(tone_external_pass),
    .limit_select(limit_select),
    .limit_static(limit_static),
    .voltage_select(voltage_select),
    .power_stage_en(power_stage_en)
  );
  lnb_host_model lnb_host_model_i (
    .scl(scl),
    .sda_rel(sda_rel),
    .sda_wire(sda_wire)
  );
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #62.5 link_clk = ~link_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (fail_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // address plus two data bytes; ok says whether acks are expected
  task automatic wr2(input logic [6:0] a, input logic [7:0] b0,
      input logic [7:0] b1, input logic ok);
    logic [23:0] v;
    logic [7:0] r;
    logic k;
    v = {a, 1'b0, b0, b1};
    lnb_host_model_i.start();
    for (int i = 2; i >= 0; i--) begin
      lnb_host_model_i.byte_io(v[i*8 +: 8], 1'b1, r, k);
      check({7'h0, k}, {7'h0, !ok});
    end
    lnb_host_model_i.stop();
  endtask
  // reads status, tone, command, control; nack after the last
  task automatic rd4(input logic [31:0] exp);
    logic [7:0] r;
    logic k;
    lnb_host_model_i.start();
    lnb_host_model_i.byte_io({DEV, 1'b1}, 1'b1, r, k);
    check({7'h0, k}, 8'h00);
    for (int i = 3; i >= 0; i--) begin
      lnb_host_model_i.byte_io(8'hFF, i == 0, r, k);
      check(r, exp[i*8 +: 8]);
    end
    lnb_host_model_i.stop();
  endtask
  initial begin
    #1_500_000;
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    #2 nrst = 1'b1;
    repeat (20) @(posedge clk);
    check(outs, 8'h00);
    rd4({8'h0A, 24'h0});
    wr2(7'h08, 8'h70, 8'h7F, 1'b0);
    check(outs, 8'h00);
    @(posedge clk) #2 pol = 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr2(DEV, {3'h2, i[0], 2'b10, i[1:0]}, {4'h7, 2'b00, i[1:0]}, 1'b1);
      check(outs, {2'b00, i[1:0], i[0], i[1:0], 1'b1});
    end
    wr2(DEV, 8'h40, 8'h72, 1'b1);
    check(outs, 8'h07);
    @(posedge clk) #2 pol = 1'b0;
    repeat (6) @(posedge clk);
    check(outs, 8'h01);
    wr2(DEV, 8'h70, 8'h62, 1'b1);
    check(outs, 8'h00);
    wr2(DEV, 8'h1F, 8'h7F, 1'b1);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) #2 ext = tab[i][4];
      wr2(DEV, {3'h1, tab[i][3:2], 3'h0}, {3'h1, tab[i][3:2], 3'h0}, 1'b1);
      check({6'h0, outs[7:6]}, {6'h0, tab[i][1:0]});
    end
    @(posedge clk) #2 flags = 5'h15;
    txp = 1'b1;
    repeat (6) @(posedge clk);
    rd4({8'h15, 8'h34, 8'h40, 8'h73});
    @(posedge clk) #2 power_ok = 1'b0;
    repeat (10) @(posedge clk);
    check(outs, 8'h00);
    wr2(DEV, 8'h70, 8'h5F, 1'b0);
    @(posedge clk) #2 power_ok = 1'b1;
    repeat (20) @(posedge clk);
    rd4({8'h15, 8'h04, 16'h0});
    finish_test();
  end
endmodule // tb_lnb_regulator_i2c_register_port
`default_nettype wire
